//--- src/lcs_defs.vh
// Constants for the link status and message port block
// How it works
// - Local error output is high when any unmasked local error condition is present.
// - Latency reporting enable output mirrors function zero device control 2 bit.
// - Training state is a 6-bit code; detect quiet 00, L0 10, etc.
// - Codes 11-1A cover standby, L1 and L2 substates.
// - Codes 20 disabled, 21-26 loopback, 27 hot reset, 28 up equalization.
// - Completion boundary bit per function; root mode bit 1 reserved; 0=64B, 1=128B.
// - Endpoint pulses one cycle per function on power allocation write; root stays idle.
// - Buffer flush/fill enable mirrors the 2-bit enable field.
// - Root mode link change event from three gated causes; idle for endpoints.
// - Two hint requester enable bits mirror bit 8 of each function's control.
// - Steering tag mode carries function zero in [2:0], one in [5:3].
// - Six virtual function enable bits and an 18-bit mode bus.
// - Message strobe high for rxMsgLen+1 cycles with parameter bytes on 8-bit bus.
// - At least one idle cycle between two received messages.
// - Receive strobe works only when the receive port attribute is set.
// - Five-bit message type is driven while the strobe is high.
// - Transmit done pulses exactly one cycle when transmission completes.
// - Transmit type 000 latency, 001 flush/fill, 010 slot power, 011 PME.
`ifndef LCS_DEFS_VH
`define LCS_DEFS_VH
`define LCS_LTSSM_W 6
`define LCS_LTSSM_DETECT_QUIET 6'h00
`define LCS_LTSSM_L0 6'h10
`define LCS_LTSSM_HOT_RESET 6'h27
`define LCS_LTSSM_RESET 6'h00
`define LCS_RCB_RESET 2'b00
`define LCS_OBFF_RESET 2'b00
`define LCS_TX_LTR 3'b000
`define LCS_TX_OBFF 3'b001
`define LCS_TX_SLOT_PWR 3'b010
`define LCS_TX_PME 3'b011
`define LCS_TX_LEN_LTR 3'h4
`define LCS_TX_LEN_OBFF 3'h1
`define LCS_TX_LEN_SLOT_PWR 3'h2
`define LCS_TX_LEN_PME 3'h2
`define LCS_SNOOP_REQ_BIT 31
`define LCS_NOSNOOP_REQ_BIT 15
`define LCS_MSG_LEN_W 3
`endif

//--- src/lcs_msg_store.v
// Small memory holding received message bytes
`timescale 1ns/1ns
module lcs_msg_store #(
  parameter DEPTH_W = 3
) (
  input wire sys_clk,
  input wire wrEn,
  input wire [DEPTH_W-1:0] wrAddr,
  input wire [7:0] wrData,
  input wire [DEPTH_W-1:0] rdAddr,
  output reg [7:0] rdData
);
  reg [7:0] mem [0:(1<<DEPTH_W)-1];
  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

//--- src/lcs_link_status.v
// Side-band status, receive message and transmit message ports
`timescale 1ns/1ns
`include "lcs_defs.vh"
module lcs_link_status #(
  parameter NUM_PF = 2,
  parameter NUM_VF = 6,
  parameter NUM_ERR = 16,
  parameter TX_LEN_W = 3
) (
  input wire sys_clk,
  input wire reset_n,
  // Mode and attributes
  input wire rootPortMode,
  input wire rxMessagePortAttr,
  // Local error sources and masks
  input wire [NUM_ERR-1:0] localErrStatus,
  input wire [NUM_ERR-1:0] localErrMask,
  output reg localError,
  // Mirrored configuration fields
  input wire pf0LtrMechEnable,
  output reg latencyReportEnable,
  input wire [5:0] ltssmCode,
  output reg [5:0] linkTrainingState,
  input wire [NUM_PF-1:0] pfRcbBit,
  output reg [NUM_PF-1:0] completionBoundary,
  input wire [NUM_PF-1:0] dpaCtrlWrite,
  output reg [NUM_PF-1:0] powerAllocChange,
  input wire [1:0] obffEnableField,
  output reg [1:0] bufferFlushFillEnable,
  input wire bwMgmtStatus,
  input wire bwMgmtIntEnable,
  input wire autoBwStatus,
  input wire autoBwIntEnable,
  input wire eqRequestStatus,
  input wire eqRequestIntEnable,
  output reg linkChangeEvent,
  input wire [16*NUM_PF-1:0] pfHintReqCtrl,
  output reg [NUM_PF-1:0] pfHintRequesterEnable,
  output reg [3*NUM_PF-1:0] pfSteeringTagMode,
  input wire [16*NUM_VF-1:0] vfHintReqCtrl,
  output reg [NUM_VF-1:0] vfHintRequesterEnable,
  output reg [3*NUM_VF-1:0] vfSteeringTagMode,
  // Decoded message from the link receive path
  input wire rxMsgValid,
  input wire [4:0] rxMsgKind,
  input wire [`LCS_MSG_LEN_W-1:0] rxMsgLen,
  input wire [63:0] rxMsgParams,
  output wire rxMsgReady,
  output reg msgReceived,
  output reg [7:0] msgReceivedData,
  output reg [4:0] msgReceivedType,
  // Transmit message request
  input wire msgTransmit,
  input wire [2:0] msgTransmitType,
  input wire [31:0] msgTransmitData,
  output reg msgTransmitDone,
  // Towards the link transmit path, one byte per accepted beat
  output reg txLinkValid,
  output reg [7:0] txLinkByte,
  output reg txLinkLast,
  input wire txLinkReady
);
  localparam RX_IDLE = 2'b00;
  localparam RX_SEND = 2'b01;
  localparam RX_GAP = 2'b10;
  localparam TX_IDLE = 2'b00;
  localparam TX_SEND = 2'b01;
  localparam TX_DONE = 2'b10;
  localparam TX_HOLD = 2'b11;

  // Beats on the link for each transmit type
  function [TX_LEN_W-1:0] txBeats;
    input [2:0] kind;
    begin
      case (kind)
        `LCS_TX_LTR: txBeats = `LCS_TX_LEN_LTR;
        `LCS_TX_OBFF: txBeats = `LCS_TX_LEN_OBFF;
        `LCS_TX_SLOT_PWR: txBeats = `LCS_TX_LEN_SLOT_PWR;
        `LCS_TX_PME: txBeats = `LCS_TX_LEN_PME;
        default: txBeats = {TX_LEN_W{1'b0}};
      endcase
    end
  endfunction

  // Byte n of the transmit data, keeping only the fields each type defines
  function [7:0] txByte;
    input [2:0] kind;
    input [31:0] data;
    input [1:0] idx;
    reg [31:0] clean;
    begin
      clean = 32'h0000_0000;
      case (kind)
        `LCS_TX_LTR: clean = data & 32'h9FFF_9FFF;
        `LCS_TX_OBFF: clean = data & 32'h0000_000F;
        `LCS_TX_SLOT_PWR: clean = data & 32'h0000_03FF;
        `LCS_TX_PME: clean = data & 32'h0000_03F3;
        default: clean = 32'h0000_0000;
      endcase
      txByte = clean[idx*8 +: 8];
    end
  endfunction

  // Status mirrors, registered so outputs come from flip-flops
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      localError <= 1'b0;
      latencyReportEnable <= 1'b0;
      linkTrainingState <= `LCS_LTSSM_RESET;
      completionBoundary <= {NUM_PF{1'b0}};
      powerAllocChange <= {NUM_PF{1'b0}};
      bufferFlushFillEnable <= `LCS_OBFF_RESET;
      linkChangeEvent <= 1'b0;
    end else begin
      localError <= |(localErrStatus & ~localErrMask);
      latencyReportEnable <= pf0LtrMechEnable;
      linkTrainingState <= ltssmCode;
      completionBoundary <= pfRcbBit;
      if (rootPortMode) begin
        // Bit 1 is reserved for the root port
        completionBoundary[1] <= 1'b0;
      end
      // Write strobe from the config path is already one cycle wide
      powerAllocChange <= rootPortMode ? {NUM_PF{1'b0}} : dpaCtrlWrite;
      bufferFlushFillEnable <= obffEnableField;
      linkChangeEvent <= rootPortMode & ((bwMgmtStatus & bwMgmtIntEnable) |
        (autoBwStatus & autoBwIntEnable) | (eqRequestStatus & eqRequestIntEnable));
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PF; g = g + 1) begin : pfHint
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          pfHintRequesterEnable[g] <= 1'b0;
          pfSteeringTagMode[3*g +: 3] <= 3'h0;
        end else begin
          pfHintRequesterEnable[g] <= pfHintReqCtrl[16*g + 8];
          pfSteeringTagMode[3*g +: 3] <= pfHintReqCtrl[16*g +: 3];
        end
      end
    end
    for (g = 0; g < NUM_VF; g = g + 1) begin : vfHint
      always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          vfHintRequesterEnable[g] <= 1'b0;
          vfSteeringTagMode[3*g +: 3] <= 3'h0;
        end else begin
          vfHintRequesterEnable[g] <= vfHintReqCtrl[16*g + 8];
          vfSteeringTagMode[3*g +: 3] <= vfHintReqCtrl[16*g +: 3];
        end
      end
    end
  endgenerate

  // Receive message delivery: message bytes stored, then streamed from the store
  reg [1:0] rxState;
  reg [`LCS_MSG_LEN_W-1:0] rxCount;
  reg [`LCS_MSG_LEN_W-1:0] rxLast;
  reg [4:0] rxKind;
  reg [7:0] loadIdx;
  wire [7:0] storeData;
  wire [`LCS_MSG_LEN_W-1:0] rdPtr;

  // Taking a message only from idle guarantees the gap cycle between messages
  assign rxMsgReady = (rxState == RX_IDLE) & rxMessagePortAttr;
  // Address runs one byte ahead of delivery once streaming, so the store's register keeps up
  assign rdPtr = (loadIdx == 8'h02) ? rxCount + 1'b1 : rxCount;

  // Parameters arrive as a 64-bit word; a loader writes them one byte per cycle
  reg loadBusy;
  reg [63:0] loadWord;
  reg [`LCS_MSG_LEN_W-1:0] loadPtr;
  wire doLoad = loadBusy;

  lcs_msg_store #(
    .DEPTH_W(`LCS_MSG_LEN_W)
  ) uStore (
    .sys_clk(sys_clk),
    .wrEn(doLoad),
    .wrAddr(loadPtr),
    .wrData(loadWord[7:0]),
    .rdAddr(rdPtr),
    .rdData(storeData)
  );

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxState <= RX_IDLE;
      rxCount <= {`LCS_MSG_LEN_W{1'b0}};
      rxLast <= {`LCS_MSG_LEN_W{1'b0}};
      rxKind <= 5'h00;
      loadBusy <= 1'b0;
      loadWord <= 64'h0000_0000_0000_0000;
      loadPtr <= {`LCS_MSG_LEN_W{1'b0}};
      loadIdx <= 8'h00;
      msgReceived <= 1'b0;
      msgReceivedData <= 8'h00;
      msgReceivedType <= 5'h00;
    end else begin
      case (rxState)
        RX_IDLE: begin
          msgReceived <= 1'b0;
          if (rxMsgValid && rxMessagePortAttr) begin
            rxKind <= rxMsgKind;
            rxLast <= rxMsgLen;
            loadWord <= rxMsgParams;
            loadPtr <= {`LCS_MSG_LEN_W{1'b0}};
            loadBusy <= 1'b1;
            loadIdx <= 8'h00;
            rxCount <= {`LCS_MSG_LEN_W{1'b0}};
            rxState <= RX_SEND;
          end
        end
        RX_SEND: begin
          // Byte k is written at one edge, read at the next and delivered at the one after
          if (loadBusy) begin
            loadWord <= {8'h00, loadWord[63:8]};
            loadPtr <= loadPtr + 1'b1;
            if (loadPtr == rxLast) begin
              loadBusy <= 1'b0;
            end
          end
          if (loadIdx != 8'h02) begin
            loadIdx <= loadIdx + 8'h01;
          end else begin
            msgReceived <= 1'b1;
            msgReceivedType <= rxKind;
            msgReceivedData <= storeData;
            rxCount <= rxCount + 1'b1;
            if (rxCount == rxLast) begin
              rxState <= RX_GAP;
            end
          end
        end
        RX_GAP: begin
          // Forced strobe-low cycle before the next message
          msgReceived <= 1'b0;
          msgReceivedType <= 5'h00;
          msgReceivedData <= 8'h00;
          rxState <= RX_IDLE;
        end
        default: begin
          rxState <= RX_IDLE;
          msgReceived <= 1'b0;
        end
      endcase
    end
  end

  // Transmit message engine
  reg [1:0] txState;
  reg [TX_LEN_W-1:0] txCount;
  reg [TX_LEN_W-1:0] txTotal;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txState <= TX_IDLE;
      txCount <= {TX_LEN_W{1'b0}};
      txTotal <= {TX_LEN_W{1'b0}};
      txLinkValid <= 1'b0;
      txLinkByte <= 8'h00;
      txLinkLast <= 1'b0;
      msgTransmitDone <= 1'b0;
    end else begin
      msgTransmitDone <= 1'b0;
      case (txState)
        TX_IDLE: begin
          // Reserved types are never sent but still answered, so the user is not hung
          if (msgTransmit) begin
            txTotal <= txBeats(msgTransmitType);
            txCount <= {TX_LEN_W{1'b0}};
            if (txBeats(msgTransmitType) == {TX_LEN_W{1'b0}}) begin
              txState <= TX_DONE;
            end else begin
              txLinkValid <= 1'b1;
              txLinkByte <= txByte(msgTransmitType, msgTransmitData, 2'd0);
              txLinkLast <= (txBeats(msgTransmitType) == 1);
              txState <= TX_SEND;
            end
          end
        end
        TX_SEND: begin
          if (txLinkReady) begin
            if (txLinkLast) begin
              txLinkValid <= 1'b0;
              txLinkLast <= 1'b0;
              txState <= TX_DONE;
            end else begin
              txCount <= txCount + 1'b1;
              // Request inputs are held stable by the user until done
              txLinkByte <= txByte(msgTransmitType, msgTransmitData,
                txCount[1:0] + 2'd1);
              txLinkLast <= (txCount + 2'd2 == txTotal);
            end
          end
        end
        TX_DONE: begin
          msgTransmitDone <= 1'b1;
          txState <= TX_HOLD;
        end
        TX_HOLD: begin
          // Lets the user drop its request before a new one is seen
          txState <= TX_IDLE;
        end
        default: begin
          txState <= TX_IDLE;
        end
      endcase
    end
  end
endmodule

//--- testbench/lcs_link_status_monitor.sv
// Concurrent checks on the link status block ports
`timescale 1ns/1ns
module lcs_status_monitor #(
  parameter NUM_PF = 2,
  parameter NUM_ERR = 16
) (
  input wire sys_clk,
  input wire reset_n,
  input wire rootPortMode,
  input wire [NUM_ERR-1:0] localErrStatus,
  input wire [NUM_ERR-1:0] localErrMask,
  input wire localError,
  input wire pf0LtrMechEnable,
  input wire latencyReportEnable,
  input wire [5:0] ltssmCode,
  input wire [5:0] linkTrainingState,
  input wire [NUM_PF-1:0] dpaCtrlWrite,
  input wire [NUM_PF-1:0] powerAllocChange,
  input wire [16*NUM_PF-1:0] pfHintReqCtrl,
  input wire [NUM_PF-1:0] pfHintRequesterEnable,
  input wire msgReceived,
  input wire [4:0] msgReceivedType,
  input wire msgTransmit,
  input wire msgTransmitDone
);
  reg up;
  // Mirrors lag one edge, so the first edge after reset still sees stale inputs
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      up <= 1'b0;
    end else begin
      up <= 1'b1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_err; up |-> localError == |($past(localErrStatus) & ~$past(localErrMask)); endproperty
  a_err: assert property (p_err) else $error("local error flag wrong");
  property p_ltr; up |-> latencyReportEnable == $past(pf0LtrMechEnable); endproperty
  a_ltr: assert property (p_ltr) else $error("latency enable wrong");
  property p_ltssm; up |-> linkTrainingState == $past(ltssmCode); endproperty
  a_ltssm: assert property (p_ltssm) else $error("training state wrong");
  property p_pwr;
    up |-> powerAllocChange == ($past(rootPortMode) ? {NUM_PF{1'b0}} : $past(dpaCtrlWrite));
  endproperty
  a_pwr: assert property (p_pwr) else $error("power change pulse wrong");
  property p_hint;
    up |-> pfHintRequesterEnable == {$past(pfHintReqCtrl[24]), $past(pfHintReqCtrl[8])};
  endproperty
  a_hint: assert property (p_hint) else $error("hint enable wrong");
  property p_gap; $fell(msgReceived) |-> !msgReceived ##1 !msgReceived; endproperty
  a_gap: assert property (p_gap) else $error("no gap between messages");
  property p_type; msgReceived && $past(msgReceived) |-> $stable(msgReceivedType); endproperty
  a_type: assert property (p_type) else $error("message type moved");
  property p_done; msgTransmitDone |-> msgTransmit ##1 !msgTransmitDone; endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
endmodule
bind lcs_link_status lcs_status_monitor #(.NUM_PF(NUM_PF), .NUM_ERR(NUM_ERR)) u_mon (.*);

//--- testbench/lcs_link_sink.sv
// Link-side byte sink that can stall the transmit path
`timescale 1ns/1ns
module lcs_link_sink (
  input wire sys_clk,
  input wire reset_n,
  input wire stall,
  output reg txLinkReady
);
  integer seed = 78;
  // Random stalls force the sender to hold a byte across idle edges whenever ready drops
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txLinkReady <= 1'b0;
    end else begin
      txLinkReady <= stall ? $random(seed) : 1'b1;
    end
  end
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the link status and message port block
`timescale 1ns/1ns
module testbench;
  reg sys_clk = 0, reset_n = 0, rootPortMode = 0, rxMessagePortAttr = 1, pf0LtrMechEnable = 0;
  reg bwMgmtStatus = 0, bwMgmtIntEnable = 0, autoBwStatus = 0, autoBwIntEnable = 0;
  reg eqRequestStatus = 0, eqRequestIntEnable = 0, rxMsgValid = 0, msgTransmit = 0, stall = 0;
  reg [15:0] localErrStatus = 0, localErrMask = 0;
  reg [5:0] ltssmCode = 0;
  reg [1:0] pfRcbBit = 0, dpaCtrlWrite = 0, obffEnableField = 0;
  reg [31:0] pfHintReqCtrl = 0, msgTransmitData = 0;
  reg [95:0] vfHintReqCtrl = 0;
  reg [4:0] rxMsgKind = 0;
  reg [2:0] rxMsgLen = 0, msgTransmitType = 0;
  reg [63:0] rxMsgParams = 0, eMir = 0;
  wire localError, latencyReportEnable, linkChangeEvent, rxMsgReady, msgReceived;
  wire msgTransmitDone, txLinkValid, txLinkLast, txLinkReady;
  wire [5:0] linkTrainingState, vfHintRequesterEnable, pfSteeringTagMode;
  wire [1:0] completionBoundary, powerAllocChange, bufferFlushFillEnable, pfHintRequesterEnable;
  wire [17:0] vfSteeringTagMode;
  wire [7:0] msgReceivedData, txLinkByte;
  wire [4:0] msgReceivedType;
  integer err_count = 0, checks_done = 0, seed = 78, i, k, n;
  lcs_link_status uut (.*);
  lcs_link_sink sink (.sys_clk(sys_clk), .reset_n(reset_n), .stall(stall), .txLinkReady(txLinkReady));
  initial forever #4 sys_clk = ~sys_clk;
  // Status outputs follow their sources one edge late, so the model samples on that edge
  always @(posedge sys_clk) eMir <= {|(localErrStatus & ~localErrMask), pf0LtrMechEnable,
    ltssmCode, pfRcbBit[1] & ~rootPortMode, pfRcbBit[0], rootPortMode ? 2'b00 : dpaCtrlWrite,
    obffEnableField, rootPortMode & |({bwMgmtStatus, autoBwStatus, eqRequestStatus}
    & {bwMgmtIntEnable, autoBwIntEnable, eqRequestIntEnable}), pfHintReqCtrl[24],
    pfHintReqCtrl[8], pfHintReqCtrl[18:16], pfHintReqCtrl[2:0], vfHintReqCtrl[88],
    vfHintReqCtrl[72], vfHintReqCtrl[56], vfHintReqCtrl[40], vfHintReqCtrl[24], vfHintReqCtrl[8],
    vfHintReqCtrl[82:80], vfHintReqCtrl[66:64], vfHintReqCtrl[50:48], vfHintReqCtrl[34:32],
    vfHintReqCtrl[18:16], vfHintReqCtrl[2:0]};
  task results;
    begin
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [63:0] e, input [63:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("mismatch %0s expected %0h seen %0h", nm, e, g);
      end
      if (nm == "timeout") results;
    end
  endtask
  task rx(input [4:0] kd, input [2:0] ln);
    reg [63:0] pr;
    begin
      pr = {$random(seed), $random(seed)};
      @(posedge sys_clk);
      rxMsgKind <= kd;
      rxMsgLen <= ln;
      rxMsgParams <= pr;
      n = 0;
      while (!rxMsgReady && n < 20) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      if (n == 20) chk("timeout", 0, 1);
      @(posedge sys_clk);
      rxMsgValid <= 1;
      @(posedge sys_clk);
      rxMsgValid <= 0;
      k = 0;
      for (n = 0; n < 14; n = n + 1) begin
        @(negedge sys_clk);
        if (msgReceived) begin
          chk("rxtype", kd, msgReceivedType);
          chk("rxbyte", pr[8*k +: 8], msgReceivedData);
          k = k + 1;
        end
      end
      chk("rxbeats", ln + 1, k);
    end
  endtask
  task tx(input [2:0] t);
    reg [31:0] d, m;
    integer nb;
    begin
      d = $random(seed);
      nb = t[2] ? 0 : t == 0 ? 4 : t == 1 ? 1 : 2;
      m = t == 0 ? 32'h9FFF_9FFF : t == 1 ? 32'h0000_000F : t == 2 ? 32'h0000_03FF : 32'h0000_03F3;
      @(posedge sys_clk);
      msgTransmit <= 1;
      msgTransmitType <= t;
      msgTransmitData <= d;
      k = 0;
      n = 0;
      while (n < 60) begin
        @(negedge sys_clk);
        n = msgTransmitDone ? 99 : n + 1;
        if (txLinkValid && txLinkReady) begin
          chk("txbyte", (d & m) >> (8 * k) & 8'hFF, txLinkByte);
          chk("txlast", k == nb - 1, txLinkLast);
          k = k + 1;
        end
      end
      chk(n < 99 ? "timeout" : "txdone", 99, n);
      chk("txbeats", nb, k);
      @(posedge sys_clk);
      msgTransmit <= 0;
      @(negedge sys_clk);
      chk("donepulse", 0, msgTransmitDone);
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1;
    for (i = 0; i < 120; i = i + 1) begin
      @(posedge sys_clk);
      {localErrStatus, localErrMask} <= {$random(seed), $random(seed) | $random(seed)};
      {pf0LtrMechEnable, ltssmCode, pfRcbBit, obffEnableField, rootPortMode} <= $random(seed);
      {bwMgmtStatus, bwMgmtIntEnable, autoBwStatus, autoBwIntEnable} <= $random(seed);
      {eqRequestStatus, eqRequestIntEnable} <= $random(seed);
      dpaCtrlWrite <= i[0] ? $random(seed) : 2'b00;
      pfHintReqCtrl <= $random(seed);
      vfHintReqCtrl <= {$random(seed), $random(seed), $random(seed)};
      @(negedge sys_clk);
      if (i > 0) chk("mirror", eMir, {localError, latencyReportEnable, linkTrainingState,
        completionBoundary, powerAllocChange, bufferFlushFillEnable, linkChangeEvent,
        pfHintRequesterEnable, pfSteeringTagMode, vfHintRequesterEnable,
        vfSteeringTagMode});
    end
    for (i = 0; i < 8; i = i + 1) rx(i * 4 + 1, i);
    @(posedge sys_clk);
    rxMessagePortAttr <= 0;
    rxMsgValid <= 1;
    for (i = 0; i < 6; i = i + 1) begin
      @(negedge sys_clk);
      chk("rxoff", 0, {rxMsgReady, msgReceived});
    end
    @(posedge sys_clk);
    rxMsgValid <= 0;
    rxMessagePortAttr <= 1;
    for (i = 0; i < 16; i = i + 1) begin
      stall <= i[3];
      tx(i[2:0]);
    end
    results;
  end
endmodule
